// File: pkg/tcs_pkg.sv
// constants, types and register map of the temperature conversion sequencer
// assumes one 10 MHz clock and an analog front end that reports one reading per request
//
// Operation
// RULE1: run continuous conversions from reset, unprompted
// RULE2: order each pass local, remote one, remote two
// RULE3: per-channel enable bits; disabled channels skipped
// RULE4: four-bit rate field sets pass repeat period
// RULE5: 12-bit results, 0.0625 degree steps, two bytes
// RULE6: standard mode clamps below zero, saturates 128
// RULE7: range bit selects extended format next conversion
// RULE8: extended mode adds 64 degree offset
// RULE9: extended span clamps high byte 00 and FF
// RULE10: low byte fraction bits 7:4, bits 3:0 zero; standard saturation stores low byte FF
// RULE11: all enables clear means shutdown; any resumes
// RULE12: both result bytes update together per conversion
package tcs_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS  = 100;        // system clock period
  localparam int unsigned MS_NS          = 1000000;    // one millisecond in ns
  localparam int unsigned MS_CYCLES_DFLT = MS_NS / CLK_PERIOD_NS;
  localparam logic [14:0] RATE_BASE_MS   = 15'h3e80;   // 16000 ms period at code 0
  localparam logic [3:0]  RATE_MAX_CODE  = 4'h8;       // faster codes run as code 8

  // register offsets
  localparam logic [7:0] ADDR_CFG1_RD   = 8'h03;  // channel_config_one
  localparam logic [7:0] ADDR_CFG1_WR   = 8'h09;  // channel_config_one write alias
  localparam logic [7:0] ADDR_RATE      = 8'h0a;  // conversion_rate
  localparam logic [7:0] ADDR_CFG2      = 8'h41;  // channel_config_two
  localparam logic [7:0] ADDR_LOC_HI    = 8'h00;  // local temperature high byte
  localparam logic [7:0] ADDR_LOC_LO    = 8'h30;  // local temperature low byte
  localparam logic [7:0] ADDR_RM1_HI    = 8'h01;  // remote one high byte
  localparam logic [7:0] ADDR_RM1_LO    = 8'h10;  // remote one low byte
  localparam logic [7:0] ADDR_RM2_HI    = 8'h23;  // remote two high byte
  localparam logic [7:0] ADDR_RM2_LO    = 8'h24;  // remote two low byte

  // field positions and reset values
  localparam int unsigned CFG1_RANGE_BIT = 2;     // extended range select
  localparam int unsigned RATE_W         = 4;     // rate_select_field width
  localparam int unsigned NUM_CHAN       = 3;     // local, remote one, remote two
  localparam logic [7:0]  CFG1_RST       = 8'h00;
  localparam logic [7:0]  RATE_RST       = 8'h06; // 250 ms period
  localparam logic [7:0]  CFG2_RST       = 8'h07; // all channels enabled

  // channel indices
  localparam logic [1:0] CHAN_LOCAL = 2'h0;
  localparam logic [1:0] CHAN_LAST  = 2'h2;

  // result formatting, readings in 1/16 degree
  localparam int unsigned       FRAC_W     = 4;          // fraction bits of a reading
  localparam logic signed [16:0] EXT_OFFSET = 17'sh00400; // +64 degrees
  localparam logic signed [16:0] STD_LIMIT  = 17'sh00800; // 128 degrees
  localparam logic signed [16:0] EXT_LIMIT  = 17'sh01000; // 256 coded degrees

  // one channel's result, high byte then low byte
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } tcs_result_t;

  localparam tcs_result_t RES_ZERO    = '{hi: 8'h00, lo: 8'h00};
  localparam tcs_result_t RES_STD_MAX = '{hi: 8'h7f, lo: 8'hff};
  localparam tcs_result_t RES_EXT_MAX = '{hi: 8'hff, lo: 8'hf0};

  // register port request
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } tcs_reg_req_t;

  // sequencer states, gray along idle-start-wait-rest
  typedef enum logic [1:0] {
    TCS_IDLE  = 2'b00,
    TCS_START = 2'b01,
    TCS_WAIT  = 2'b11,
    TCS_REST  = 2'b10
  } tcs_state_t;

endpackage

// File: design/tcs_result_mem.sv
// result store: one two-byte entry per channel, read data registered
// assumes writer and reader share clk_sys; one write and one read port
`timescale 1ns/1ps
module tcs_result_mem (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // write port
  input  wire logic                wrEn,
  input  wire logic [1:0]          wrIdx,
  input  wire tcs_pkg::tcs_result_t wrData,
  // read port
  input  wire logic [1:0]          rdIdx,
  output tcs_pkg::tcs_result_t     rdData
);

  tcs_pkg::tcs_result_t mem_q [tcs_pkg::NUM_CHAN];  // one entry per channel
  tcs_pkg::tcs_result_t rdData_q;                   // registered read data

  // whole entry written at once so a reader never sees a split pair
  generate
    for (genvar i = 0; i < tcs_pkg::NUM_CHAN; i++) begin : g_entry
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          mem_q[i] <= tcs_pkg::RES_ZERO;
        end else if (wrEn && wrIdx == 2'(i)) begin
          mem_q[i] <= wrData;  // RULE12
        end
      end
    end
  endgenerate

  // registered read; out-of-range index reads zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdData_q <= tcs_pkg::RES_ZERO;
    end else if (rdIdx <= tcs_pkg::CHAN_LAST) begin
      rdData_q <= mem_q[rdIdx];
    end else begin
      rdData_q <= tcs_pkg::RES_ZERO;
    end
  end

  assign rdData = rdData_q;

endmodule

// File: design/tcs_sequencer.sv
// conversion sequencer and result formatter of a three-channel temperature monitor
// assumes the serial protocol engine drives the register port on clk_sys and the
// analog front end answers each start with one done pulse carrying the reading
`timescale 1ns/1ps
module tcs_sequencer #(
  parameter int unsigned MS_CYCLES = tcs_pkg::MS_CYCLES_DFLT  // clocks per millisecond
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // register port from the serial engine
  input  wire tcs_pkg::tcs_reg_req_t regReq,
  output logic [7:0]              regRdData,
  output logic                    regRdValid,
  // analog front end
  output logic                    adcStart,
  output logic [1:0]              adcChan,
  input  wire logic               adcDone,
  input  wire logic signed [15:0] adcTemp,
  // status
  output logic                    convBusy,
  output logic                    shutdownActive
);

  // configuration registers
  logic [7:0]              cfg1_q;        // channel_config_one
  logic [7:0]              rate_q;        // conversion_rate
  logic [7:0]              cfg2_q;        // channel_config_two
  logic [2:0]              chanEnable;    // remote_two, remote_one, local enables
  logic                    extRange;      // extended format selected
  logic [tcs_pkg::RATE_W-1:0] rateSelectField;

  // sequencer state
  tcs_pkg::tcs_state_t     state_q;
  tcs_pkg::tcs_state_t     state_d;
  logic [1:0]              chan_q;        // channel being converted
  logic [1:0]              chan_d;
  logic                    adcStart_q;    // one-cycle start request
  logic                    passStart;     // a new pass begins this cycle
  logic                    allOff;        // every channel disabled
  logic [2:0]              nextFromCur;   // {found, idx} after current channel
  logic [2:0]              firstOfPass;   // {found, idx} from local channel

  // rate timing
  logic [31:0]             msDiv_q;       // millisecond divider
  logic                    msTick;        // one-cycle enable per millisecond
  logic [14:0]             passMs_q;      // ms elapsed since pass start
  logic [14:0]             periodMs;      // selected pass period
  logic [3:0]              rateCode;      // rate code capped to the table
  logic                    periodDone;

  // result path
  tcs_pkg::tcs_result_t    newResult;
  tcs_pkg::tcs_result_t    memRdData;
  logic [1:0]              memRdIdx;
  logic                    rdPend_q;      // read waiting for memory data
  logic                    rdSelLo_q;     // pending read wants low byte
  logic                    rdFromMem_q;   // pending read targets a result
  logic [7:0]              rdCfg_q;       // pending config read value
  logic [7:0]              regRdData_q;
  logic                    regRdValid_q;
  logic                    rdIsMem;
  logic                    rdIsLo;

  assign chanEnable      = cfg2_q[2:0];
  assign extRange        = cfg1_q[tcs_pkg::CFG1_RANGE_BIT];
  assign rateSelectField = rate_q[tcs_pkg::RATE_W-1:0];
  assign allOff          = (chanEnable == 3'h0);

  // lowest enabled channel at or above a start index, or not found
  function automatic logic [2:0] findChan(input logic [2:0] en, input logic [2:0] from);
    logic [2:0] res;
    res = 3'h0;
    for (int i = tcs_pkg::NUM_CHAN - 1; i >= 0; i--) begin
      if (en[i] && 3'(i) >= from) begin
        res = {1'b1, 2'(i)};
      end
    end
    return res;
  endfunction

  // reading in 1/16 degree to the stored two-byte format
  function automatic tcs_pkg::tcs_result_t fmtResult(input logic signed [15:0] t,
                                                     input logic ext);
    logic signed [16:0] v;
    tcs_pkg::tcs_result_t r;
    v = 17'(t);
    r = tcs_pkg::RES_ZERO;
    if (ext) begin
      v = v + tcs_pkg::EXT_OFFSET;  // RULE8
    end
    if (v < 17'sh0) begin
      r = tcs_pkg::RES_ZERO;  // RULE6 RULE9
    end else if (!ext && v >= tcs_pkg::STD_LIMIT) begin
      r = tcs_pkg::RES_STD_MAX;  // RULE6
    end else if (ext && v >= tcs_pkg::EXT_LIMIT) begin
      r = tcs_pkg::RES_EXT_MAX;  // RULE9
    end else begin
      // whole degrees above, sixteenths in the top nibble below
      r.hi = v[tcs_pkg::FRAC_W +: 8];  // RULE5
      r.lo = {v[tcs_pkg::FRAC_W-1:0], 4'h0};  // RULE10
    end
    return r;
  endfunction

  // register writes; 09h is a write alias of channel_config_one
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg1_q <= tcs_pkg::CFG1_RST;
      rate_q <= tcs_pkg::RATE_RST;
      cfg2_q <= tcs_pkg::CFG2_RST;  // RULE1
    end else if (regReq.wrEn) begin
      case (regReq.addr)
        tcs_pkg::ADDR_CFG1_RD,
        tcs_pkg::ADDR_CFG1_WR: begin
          cfg1_q <= regReq.wrData;  // RULE7
        end
        tcs_pkg::ADDR_RATE: begin
          rate_q <= {4'h0, regReq.wrData[tcs_pkg::RATE_W-1:0]};  // RULE4
        end
        tcs_pkg::ADDR_CFG2: begin
          cfg2_q <= {5'h00, regReq.wrData[2:0]};  // RULE3
        end
        default: begin
          cfg1_q <= cfg1_q;  // unmapped or read-only: ignored
        end
      endcase
    end
  end

  // millisecond enable from the system clock
  always_ff @(posedge clk_sys) begin
    if (rst || msDiv_q >= MS_CYCLES - 1) begin
      msDiv_q <= 32'h0;
    end else begin
      msDiv_q <= msDiv_q + 32'h1;
    end
  end
  assign msTick = (msDiv_q >= MS_CYCLES - 1);

  // period halves per rate step; codes above the top run at the top rate
  assign rateCode   = (rateSelectField > tcs_pkg::RATE_MAX_CODE) ?
                      tcs_pkg::RATE_MAX_CODE : rateSelectField;
  assign periodMs   = tcs_pkg::RATE_BASE_MS >> rateCode;  // RULE4
  assign periodDone = (passMs_q >= periodMs);

  // time since the current pass began, saturating
  always_ff @(posedge clk_sys) begin
    if (rst || passStart) begin
      passMs_q <= 15'h0;
    end else if (msTick && !periodDone) begin
      passMs_q <= passMs_q + 15'h1;
    end
  end

  assign nextFromCur = findChan(chanEnable, 3'(chan_q) + 3'h1);  // RULE2 RULE3
  assign firstOfPass = findChan(chanEnable, 3'(tcs_pkg::CHAN_LOCAL));  // RULE2

  // next state: start, wait for the reading, step on, rest out the period
  always_comb begin
    state_d   = state_q;
    chan_d    = chan_q;
    passStart = 1'b0;
    case (state_q)
      tcs_pkg::TCS_IDLE: begin
        // shutdown until some channel is enabled again
        if (!allOff) begin
          state_d   = tcs_pkg::TCS_START;  // RULE11
          chan_d    = firstOfPass[1:0];
          passStart = 1'b1;
        end
      end
      tcs_pkg::TCS_START: begin
        state_d = tcs_pkg::TCS_WAIT;
      end
      tcs_pkg::TCS_WAIT: begin
        if (adcDone) begin
          if (nextFromCur[2]) begin
            state_d = tcs_pkg::TCS_START;  // RULE3
            chan_d  = nextFromCur[1:0];
          end else begin
            state_d = tcs_pkg::TCS_REST;
          end
        end
      end
      tcs_pkg::TCS_REST: begin
        // repeat the pass once the selected period has run out
        if (periodDone) begin
          state_d   = tcs_pkg::TCS_START;  // RULE1 RULE4
          chan_d    = firstOfPass[1:0];
          passStart = 1'b1;
        end
      end
      default: begin
        state_d = tcs_pkg::TCS_IDLE;
      end
    endcase
    // clearing every enable aborts whatever is in flight
    if (allOff) begin
      state_d   = tcs_pkg::TCS_IDLE;  // RULE11
      passStart = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= tcs_pkg::TCS_IDLE;
      chan_q  <= tcs_pkg::CHAN_LOCAL;
    end else begin
      state_q <= state_d;
      chan_q  <= chan_d;
    end
  end

  // start request to the front end, one cycle per conversion
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      adcStart_q <= 1'b0;
    end else begin
      adcStart_q <= (state_d == tcs_pkg::TCS_START) && (state_q != tcs_pkg::TCS_START);
    end
  end

  // format uses the range bit at completion, so a mode change shows from the
  // next finished conversion; a done seen outside WAIT is dropped
  assign newResult = fmtResult(adcTemp, extRange);  // RULE7

  // register read decode to a memory index
  always_comb begin
    memRdIdx = 2'h3;
    rdIsMem  = 1'b1;
    rdIsLo   = 1'b0;
    case (regReq.addr)
      tcs_pkg::ADDR_LOC_HI: memRdIdx = 2'h0;
      tcs_pkg::ADDR_RM1_HI: memRdIdx = 2'h1;
      tcs_pkg::ADDR_RM2_HI: memRdIdx = 2'h2;
      tcs_pkg::ADDR_LOC_LO: begin
        memRdIdx = 2'h0;
        rdIsLo   = 1'b1;
      end
      tcs_pkg::ADDR_RM1_LO: begin
        memRdIdx = 2'h1;
        rdIsLo   = 1'b1;
      end
      tcs_pkg::ADDR_RM2_LO: begin
        memRdIdx = 2'h2;
        rdIsLo   = 1'b1;
      end
      default: rdIsMem = 1'b0;
    endcase
  end

  tcs_result_mem u_mem (
    .clk_sys (clk_sys),
    .rst     (rst),
    .wrEn    (adcDone && state_q == tcs_pkg::TCS_WAIT && !allOff),  // RULE12 RULE11
    .wrIdx   (chan_q),
    .wrData  (newResult),
    .rdIdx   (memRdIdx),
    .rdData  (memRdData)
  );

  // first read stage: remember what was asked while memory fetches
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdPend_q    <= 1'b0;
      rdSelLo_q   <= 1'b0;
      rdFromMem_q <= 1'b0;
      rdCfg_q     <= 8'h00;
    end else begin
      rdPend_q    <= regReq.rdEn;
      rdSelLo_q   <= rdIsLo;
      rdFromMem_q <= rdIsMem;
      case (regReq.addr)
        tcs_pkg::ADDR_CFG1_RD: rdCfg_q <= cfg1_q;
        tcs_pkg::ADDR_RATE:    rdCfg_q <= rate_q;
        tcs_pkg::ADDR_CFG2:    rdCfg_q <= cfg2_q;
        default:               rdCfg_q <= 8'h00;  // unmapped reads zero
      endcase
    end
  end

  // second read stage: the asked byte of the fetched entry, or the config value
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regRdData_q  <= 8'h00;
      regRdValid_q <= 1'b0;
    end else begin
      regRdValid_q <= rdPend_q;
      if (rdPend_q) begin
        if (rdFromMem_q) begin
          regRdData_q <= rdSelLo_q ? memRdData.lo : memRdData.hi;
        end else begin
          regRdData_q <= rdCfg_q;
        end
      end
    end
  end

  assign regRdData      = regRdData_q;
  assign regRdValid     = regRdValid_q;
  assign adcStart       = adcStart_q;
  assign adcChan        = chan_q;
  assign convBusy       = (state_q == tcs_pkg::TCS_START) || (state_q == tcs_pkg::TCS_WAIT);
  assign shutdownActive = (state_q == tcs_pkg::TCS_IDLE);

endmodule

// File: verification/tcs_sequencer_props.sv
// port checker for the conversion sequencer
// assumes one clock clk_sys and synchronous active-high rst
`timescale 1ns/1ps
module tcs_seq_props #(parameter int unsigned MS_CYCLES = 4) (
  // clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rst,
  // register port
  input wire tcs_pkg::tcs_reg_req_t regReq,
  input wire logic                  regRdValid,
  // front end and status
  input wire logic                  adcStart,
  input wire logic [1:0]            adcChan,
  input wire logic                  convBusy,
  input wire logic                  shutdownActive
);
  logic [2:0] cfg2Q;   // shadow of the channel enables
  logic       dirtyQ;  // enables written since the last start
  logic [1:0] lastQ;   // channel of the last start
  logic       cfg2Wr;  // enable write seen at the port

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  assign cfg2Wr = regReq.wrEn && regReq.addr == tcs_pkg::ADDR_CFG2;

  // next enabled channel in cyclic order, local first after a wrap
  function automatic logic [1:0] nextChan(input logic [1:0] last, input logic [2:0] en);
    for (int k = 1; k <= 3; k++) if (en[(last + k) % 3]) return 2'((last + k) % 3);
    return last;
  endfunction

  // enable shadow follows port writes
  always_ff @(posedge clk_sys) if (rst) cfg2Q <= tcs_pkg::CFG2_RST[2:0];
    else if (cfg2Wr) cfg2Q <= regReq.wrData[2:0];
  // a start right after an enable change may follow either map, so it is not judged
  always_ff @(posedge clk_sys) if (rst) dirtyQ <= 1'b0;
    else if (cfg2Wr) dirtyQ <= 1'b1;
    else if (adcStart) dirtyQ <= 1'b0;
  // shutdown restarts the pass, as if channel two had just run
  always_ff @(posedge clk_sys) if (rst || shutdownActive) lastQ <= 2'h2;
    else if (adcStart) lastQ <= adcChan;

  chk_read_answer: assert property (regReq.rdEn |-> ##2 regRdValid)
    else $error("read answer missing");
  chk_valid_cause: assert property (regRdValid |-> $past(regReq.rdEn, 2))
    else $error("read answer without request");
  chk_reset_run: assert property ($fell(rst) |-> ##[1:3] adcStart)
    else $error("no conversion after reset");
  chk_start_single: assert property (adcStart |=> !adcStart)
    else $error("start longer than one cycle");
  chk_busy_start: assert property (adcStart |-> convBusy)
    else $error("start without busy");
  chk_chan_order: assert property (adcStart && !dirtyQ |-> adcChan == nextChan(lastQ, cfg2Q))
    else $error("channel order broken");
  chk_skip_off: assert property (adcStart && !dirtyQ |-> cfg2Q[adcChan])
    else $error("disabled channel converted");
  chk_chan_hold: assert property (convBusy && !adcStart |-> $stable(adcChan))
    else $error("channel moved during conversion");
  chk_sd_entry: assert property (cfg2Wr && regReq.wrData[2:0] == 3'h0 |-> ##[1:3] shutdownActive)
    else $error("shutdown not entered");
  chk_sd_quiet: assert property (shutdownActive |-> !adcStart)
    else $error("conversion during shutdown");
  chk_sd_resume: assert property (shutdownActive && cfg2Wr && regReq.wrData[2:0] != 3'h0
    |-> ##[1:4] adcStart)
    else $error("no resume after enable");
endmodule

bind tcs_sequencer tcs_seq_props #(.MS_CYCLES(MS_CYCLES)) u_props (
  .clk_sys(clk_sys), .rst(rst), .regReq(regReq), .regRdValid(regRdValid),
  .adcStart(adcStart), .adcChan(adcChan), .convBusy(convBusy),
  .shutdownActive(shutdownActive));

// File: verification/tcs_frontend_model.sv
// analog front end model: one done pulse with a reading per start
// assumes the bench sets readings and the answer delay
`timescale 1ns/1ps
module tcs_frontend_model (
  // clock
  input  wire logic             clk_sys,
  // conversion handshake
  input  wire logic             adcStart,
  input  wire logic [1:0]       adcChan,
  output logic                  adcDone,
  output logic signed [15:0]    adcTemp,
  // settings from the bench
  input  wire logic [2:0][15:0] chanTemp,
  input  wire logic [5:0]       answerDly
);
  // answer after the set delay; the reading is only good with the pulse.
  // everything is looked at 5 ns after the edge, so a start launched by an
  // edge is seen without racing it, even one launched by the answer's edge
  initial begin
    int left;  // cycles until the answer, -1 when none is due
    left    = -1;
    adcDone = 1'b0;
    adcTemp = 16'sh0000;
    forever begin
      @(posedge clk_sys);
      #5;
      if (adcDone === 1'b1) begin
        adcDone = 1'b0;
        adcTemp = ~adcTemp;  // stale value scrambled so it cannot pass by luck
      end
      if (left == 0) begin
        adcDone = 1'b1;
        adcTemp = chanTemp[adcChan];
      end
      if (left >= 0) left--;
      if (adcStart === 1'b1) left = answerDly;
    end
  end
endmodule

// File: verification/tcs_sequencer_bench.sv
// self-checking bench for the conversion sequencer
// assumes the front end model answers every start; short millisecond keeps passes brief
`timescale 1ns/1ps
module tcs_sequencer_bench;
  localparam int unsigned MSC = 4;  // clocks per simulated millisecond
  // design ports
  logic                  clk_sys = 1'b0;
  logic                  rst     = 1'b1;
  tcs_pkg::tcs_reg_req_t regReq  = '0;
  logic [7:0]            regRdData;
  logic                  regRdValid, adcStart, adcDone, convBusy, shutdownActive;
  logic [1:0]            adcChan;
  logic signed [15:0]    adcTemp;
  // model settings and bookkeeping
  logic [2:0][15:0]      chanTemp = '0;
  logic [5:0]            answerDly = 6'h02;
  int                    errTotal = 0, samplesChecked = 0, seed = 77, doneCnt = 0;
  logic [15:0]           got, expR [3];
  logic [7:0]            rd8;
  logic [7:0]            hiA [3] = '{tcs_pkg::ADDR_LOC_HI, tcs_pkg::ADDR_RM1_HI, tcs_pkg::ADDR_RM2_HI};
  logic [7:0]            loA [3] = '{tcs_pkg::ADDR_LOC_LO, tcs_pkg::ADDR_RM1_LO, tcs_pkg::ADDR_RM2_LO};
  logic [15:0]           tbl [9] = '{16'h0000, 16'hffff, 16'h07ff, 16'h0800, 16'hfc00,
                                     16'hfbff, 16'h0bff, 16'h0c00, 16'h0190};

  tcs_sequencer #(.MS_CYCLES(MSC)) dut (.clk_sys(clk_sys), .rst(rst), .regReq(regReq),
    .regRdData(regRdData), .regRdValid(regRdValid), .adcStart(adcStart), .adcChan(adcChan),
    .adcDone(adcDone), .adcTemp(adcTemp), .convBusy(convBusy), .shutdownActive(shutdownActive));
  tcs_frontend_model model (.clk_sys(clk_sys), .adcStart(adcStart), .adcChan(adcChan),
    .adcDone(adcDone), .adcTemp(adcTemp), .chanTemp(chanTemp), .answerDly(answerDly));

  always #50 clk_sys = ~clk_sys;
  // count answers so waits follow real progress
  always @(posedge clk_sys) if (adcDone === 1'b1) doneCnt++;

  task automatic testDone;
    if (errTotal == 0 && samplesChecked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samplesChecked++;
    if (g !== e) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one-cycle strobes, launched just after an edge
  task automatic regWr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys); #5; regReq.wrEn = 1'b1; regReq.addr = a; regReq.wrData = d;
    @(posedge clk_sys); #5; regReq.wrEn = 1'b0;
  endtask
  task automatic regRd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys); #5; regReq.rdEn = 1'b1; regReq.addr = a;
    @(posedge clk_sys); #5; regReq.rdEn = 1'b0;
    repeat (3) if (regRdValid !== 1'b1) begin @(posedge clk_sys); #5; end
    d = (regRdValid === 1'b1) ? regRdData : 8'hxx;
  endtask
  task automatic rdRes(input int ch, output logic [15:0] v);
    regRd(hiA[ch], v[15:8]);
    regRd(loA[ch], v[7:0]);
  endtask
  // expected result of one reading, clamps included
  function automatic logic [15:0] fmt(input logic [15:0] t, input logic ext);
    logic signed [16:0] v;
    v = $signed({t[15], t}) + (ext ? tcs_pkg::EXT_OFFSET : 17'sh00000);
    if (v < 0) return 16'h0000;
    if (!ext && v >= tcs_pkg::STD_LIMIT) return 16'h7fff;
    if (ext && v >= tcs_pkg::EXT_LIMIT) return 16'hfff0;
    return {v[11:4], v[3:0], 4'h0};
  endfunction
  // ch[2] set means any channel
  task automatic waitStart(input logic [2:0] ch);
    for (int k = 0; k < 3000; k++) begin
      @(posedge clk_sys); #1;
      if (adcStart === 1'b1 && (ch[2] || adcChan === ch[1:0])) break;
    end
  endtask
  // seven answers give every enabled channel a fresh reading
  task automatic settle;
    int c;
    c = doneCnt;
    for (int k = 0; k < 4000 && doneCnt < c + 7; k++) @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
    #5;
  endtask
  task automatic ratePeriod(input logic [7:0] code);
    int n;
    logic [3:0] c;
    c = (code[3:0] > tcs_pkg::RATE_MAX_CODE) ? tcs_pkg::RATE_MAX_CODE : code[3:0];
    regWr(tcs_pkg::ADDR_RATE, code);
    regRd(tcs_pkg::ADDR_RATE, rd8);
    chk("rate field", {12'h000, code[3:0]}, {8'h00, rd8});
    waitStart(3'h0);
    waitStart(3'h0);
    n = 0;
    do begin @(posedge clk_sys); #1; n++; end
    while (!(adcStart === 1'b1 && adcChan === 2'h0) && n < 5000);
    chk("pass period", 16'((int'(tcs_pkg::RATE_BASE_MS) >> c) * MSC), 16'(n));
  endtask

  initial begin
    #(100 * 80000);
    errTotal++;
    testDone;
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    #5;
    rst = 1'b0;
    regRd(tcs_pkg::ADDR_CFG1_RD, rd8);
    chk("cfg1 reset", {8'h00, tcs_pkg::CFG1_RST}, {8'h00, rd8});
    regRd(tcs_pkg::ADDR_CFG2, rd8);
    chk("cfg2 reset", {8'h00, tcs_pkg::CFG2_RST}, {8'h00, rd8});
    regRd(8'h55, rd8);
    chk("unmapped read", 16'h0000, {8'h00, rd8});
    ratePeriod(tcs_pkg::RATE_RST);
    ratePeriod(8'h07);
    ratePeriod(8'hff);
    ratePeriod(8'h08);
    // corner readings first, then random ones
    for (int i = 0; i < 12; i++) begin
      for (int c = 0; c < 3; c++) chanTemp[c] = (i < 9) ? tbl[(i + c) % 9] : 16'($random(seed));
      answerDly = 6'($random(seed) & 15);
      settle;
      for (int c = 0; c < 3; c++) begin
        rdRes(c, got);
        chk("standard result", fmt(chanTemp[c], 1'b0), got);
      end
      waitStart(3'h2);
      regWr(tcs_pkg::ADDR_LOC_HI, 8'hff);
      regWr(tcs_pkg::ADDR_CFG1_WR, 8'h04);
      rdRes(0, got);
      chk("format before conversion", fmt(chanTemp[0], 1'b0), got);
      settle;
      for (int c = 0; c < 3; c++) begin
        rdRes(c, got);
        chk("extended result", fmt(chanTemp[c], 1'b1), got);
      end
      regRd(tcs_pkg::ADDR_CFG1_RD, rd8);
      chk("range bit", 16'h0004, {8'h00, rd8});
      regWr(tcs_pkg::ADDR_CFG1_RD, 8'h00);
    end
    settle;
    for (int c = 0; c < 3; c++) expR[c] = fmt(chanTemp[c], 1'b0);
    answerDly = 6'h00;
    // every nonzero enable pattern; disabled channels keep their old result
    for (int e = 1; e < 8; e++) begin
      regWr(tcs_pkg::ADDR_CFG2, 8'(e));
      repeat (20) @(posedge clk_sys);
      #5;
      for (int c = 0; c < 3; c++) begin
        chanTemp[c] = 16'($random(seed));
        if (e[c]) expR[c] = fmt(chanTemp[c], 1'b0);
      end
      repeat (600) @(posedge clk_sys);
      for (int c = 0; c < 3; c++) begin
        rdRes(c, got);
        chk("enabled result", expR[c], got);
      end
    end
    regWr(tcs_pkg::ADDR_CFG2, 8'h00);
    repeat (4) @(posedge clk_sys);
    #5;
    chk("shutdown flag", 16'h0001, {15'h0000, shutdownActive});
    repeat (300) @(posedge clk_sys);
    regWr(tcs_pkg::ADDR_CFG2, 8'h06);
    waitStart(3'h4);
    chk("resume channel", 16'h0001, {14'h0000, adcChan});
    testDone;
  end
endmodule
